// >>> rtl/srfp_port.sv
// Ring bridge port: frame build, receive screening and own-frame strip
`include "srfp_defs.svh"

module srfp_port
  import srfp_pkg::*;
#(
  parameter int LEN_W  = 16,
  parameter int RD_MAX = `SRFP_RD_MAX
)
(
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              port_flush,
  input  wire logic              mode_fddi,
  input  wire logic [11:0]       lan_in_id,
  input  wire logic [11:0]       lan_out_id,
  input  wire logic [3:0]        bridge_num,
  input  wire logic [LEN_W-1:0]  lan_in_max,
  input  wire logic [LEN_W-1:0]  lan_out_max,
  input  wire logic              tx_valid,
  input  wire logic [7:0]        tx_byte,
  input  wire logic              tx_last,
  input  wire logic [7:0]        tx_fc,
  input  wire logic [47:0]       tx_da,
  input  wire logic [47:0]       tx_sa,
  input  wire logic [LEN_W-1:0]  tx_msdu_len,
  input  wire logic [31:0]       tx_fcs,
  input  wire logic              tx_fcs_given,
  output logic                   tx_ready,
  output logic                   tx_drop,
  input  wire logic              phy_ready,
  output logic                   phy_valid,
  output logic [7:0]             phy_byte,
  output logic                   phy_last,
  input  wire logic              rx_valid,
  input  wire logic [7:0]        rx_byte,
  input  wire logic              rx_last,
  input  wire logic              rx_err,
  output logic                   rx_ind_valid,
  output logic                   rx_ind_sr,
  output logic                   rx_ind_nsr,
  output logic                   rx_fwd_ok,
  output logic [2:0]             rx_rt,
  output logic [7:0]             rx_fc,
  output logic [47:0]            rx_da,
  output logic [47:0]            rx_sa
);

  if (RD_MAX < 1 || RD_MAX > `SRFP_RD_MAX || LEN_W < 8)
  begin : g_bad_param
    $error("srfp_port: unsupported parameter value");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h00_0000, b};
    for (int i = 0; i < 8; i++)
      r = r[0] ? ((r >> 1) ^ `SRFP_CRC_POLY) : (r >> 1);
    return r;
  endfunction : crc_byte

  function automatic logic lan_seen(input logic [11:0] l, input logic [3:0] n,
                                    input logic [11:0] arr [RD_MAX]);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < RD_MAX; i++)
      if (i < int'(n) && arr[i] == l)
        hit = 1'b1;
    return hit;
  endfunction : lan_seen

  // ----------------------------------------------------------------
  // Two-entry transmit buffer
  // ----------------------------------------------------------------
  logic [8:0]       mem_q [2];
  logic             wp_q, rp_q, open_q, pend_q, ready_q;
  logic [1:0]       cnt_q;
  srfp_state_e      st_q;
  logic [2:0]       bc_q;
  logic [7:0]       fc_q;
  logic [47:0]      da_sh_q, sa_sh_q;
  logic [LEN_W-1:0] len_q;
  logic [31:0]      fcs_in_q, fcs_sh_q, crc_tx_q;
  logic             given_q, expl_q, first_q;
  logic             phy_valid_q, phy_last_q, drop_q;
  logic [7:0]       phy_byte_q;
  logic [3:0]       own_q;

  // Decode for the buffer and sequencer
  wire        slot      = !phy_valid_q || phy_ready;
  wire        push      = tx_valid && ready_q;
  wire        push_hdr  = push && !open_q;
  wire [7:0]  buf_byte  = mem_q[rp_q][7:0];
  wire        buf_last  = mem_q[rp_q][8];
  wire        body_pop  = st_q == S_BODY && slot && cnt_q != 2'h0;
  wire        drop_pop  = st_q == S_DROP && cnt_q != 2'h0;
  wire        pop       = body_pop || drop_pop;
  wire [1:0]  cnt_d     = cnt_q + {1'b0, push} - {1'b0, pop};
  wire        open_d    = push ? !tx_last : open_q;
  wire        fs_out    = st_q == S_FS && slot;
  wire        idle_d    = (st_q == S_IDLE && !pend_q) || fs_out || (drop_pop && buf_last);
  // Next frame header waits for the sequencer so header registers stay stable
  wire        ready_d   = !port_flush && cnt_d != 2'h2 && (open_d || (idle_d && !push_hdr));
  wire [LEN_W-1:0] lim  = (lan_in_max < lan_out_max) ? lan_in_max : lan_out_max;
  wire        oversize  = len_q > lim;
  wire        expl_now  = first_q ? buf_byte[7] : expl_q;
  wire        keep_fcs  = given_q && !expl_now;

  // Buffer storage and pointers; flush empties it at once
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wp_q    <= 1'b0;
      rp_q    <= 1'b0;
      cnt_q   <= 2'h0;
      open_q  <= 1'b0;
      ready_q <= 1'b0;
    end
    else if (port_flush)
    begin
      wp_q    <= 1'b0;
      rp_q    <= 1'b0;
      cnt_q   <= 2'h0;
      open_q  <= 1'b0;
      ready_q <= 1'b0;
    end
    else
    begin
      if (push)
        mem_q[wp_q] <= {tx_last, tx_byte};
      wp_q    <= wp_q ^ push;
      rp_q    <= rp_q ^ pop;
      cnt_q   <= cnt_d;
      open_q  <= open_d;
      ready_q <= ready_d;
    end
  end

  // ----------------------------------------------------------------
  // Transmit sequencer
  // ----------------------------------------------------------------
  wire in_crc = st_q == S_FC || st_q == S_DA || st_q == S_SA || st_q == S_BODY;
  wire emit   = (slot && st_q != S_IDLE && st_q != S_DROP && st_q != S_BODY) || body_pop;
  wire [7:0] emit_byte = (st_q == S_SD)   ? `SRFP_SD :
                         (st_q == S_AC)   ? `SRFP_AC :
                         (st_q == S_FC)   ? fc_q :
                         (st_q == S_DA)   ? da_sh_q[47:40] :
                         (st_q == S_SA)   ? sa_sh_q[47:40] :
                         (st_q == S_BODY) ? buf_byte :
                         (st_q == S_FCS)  ? fcs_sh_q[7:0] :
                         (st_q == S_ED)   ? `SRFP_ED : `SRFP_FS;
  wire [31:0] tx_crc_nxt = crc_byte(crc_tx_q, emit_byte);

  // Header capture with the first beat of each frame
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      pend_q <= 1'b0;
    else
      pend_q <= !port_flush && (push_hdr || (pend_q && st_q != S_IDLE));
  end

  always_ff @(posedge sys_clk)
  begin
    if (push_hdr)
    begin
      fc_q     <= tx_fc;
      len_q    <= tx_msdu_len;
      fcs_in_q <= tx_fcs;
      given_q  <= tx_fcs_given;
    end
  end

  // Octet sequencing; the single ordered queue keeps every frame type in order
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      st_q        <= S_IDLE;
      bc_q        <= 3'h0;
      da_sh_q     <= 48'h0;
      sa_sh_q     <= 48'h0;
      fcs_sh_q    <= 32'h0;
      crc_tx_q    <= `SRFP_CRC_INIT;
      expl_q      <= 1'b0;
      first_q     <= 1'b0;
      phy_valid_q <= 1'b0;
      phy_byte_q  <= 8'h00;
      phy_last_q  <= 1'b0;
      drop_q      <= 1'b0;
    end
    else
    begin
      drop_q <= 1'b0;
      if (slot)
      begin
        phy_valid_q <= emit;
        phy_byte_q  <= emit_byte;
        phy_last_q  <= st_q == S_FS;
      end
      if (emit && in_crc)
        crc_tx_q <= tx_crc_nxt;
      if (body_pop)
      begin
        first_q <= 1'b0;
        if (first_q)
          expl_q <= buf_byte[7];
      end
      if (port_flush)
      begin
        st_q <= S_IDLE;
      end
      else
      begin
        case (st_q)
          S_IDLE:
            if (pend_q)
            begin
              st_q     <= oversize ? S_DROP : S_SD;
              da_sh_q  <= tx_da;
              sa_sh_q  <= tx_sa | `SRFP_RII_MASK;
              crc_tx_q <= `SRFP_CRC_INIT;
              first_q  <= 1'b1;
            end
          S_SD:   if (slot) st_q <= S_AC;
          S_AC:   if (slot) st_q <= S_FC;
          S_FC:
            if (slot)
            begin
              st_q <= S_DA;
              bc_q <= 3'h0;
            end
          S_DA:
            if (slot)
            begin
              da_sh_q <= da_sh_q << 8;
              bc_q    <= (bc_q == `SRFP_ADDR_LAST) ? 3'h0 : bc_q + 3'h1;
              if (bc_q == `SRFP_ADDR_LAST)
                st_q <= S_SA;
            end
          S_SA:
            if (slot)
            begin
              sa_sh_q <= sa_sh_q << 8;
              bc_q    <= (bc_q == `SRFP_ADDR_LAST) ? 3'h0 : bc_q + 3'h1;
              if (bc_q == `SRFP_ADDR_LAST)
                st_q <= S_BODY;
            end
          S_BODY:
            if (body_pop && buf_last)
            begin
              st_q     <= S_FCS;
              fcs_sh_q <= keep_fcs ? fcs_in_q : ~tx_crc_nxt;
            end
          S_FCS:
            if (slot)
            begin
              fcs_sh_q <= fcs_sh_q >> 8;
              bc_q     <= bc_q + 3'h1;
              if (bc_q == `SRFP_FCS_LAST)
                st_q <= S_ED;
            end
          S_ED:   if (slot) st_q <= S_FS;
          S_FS:   if (slot) st_q <= S_IDLE;
          S_DROP:
            if (drop_pop && buf_last)
            begin
              st_q   <= S_IDLE;
              drop_q <= 1'b1;
            end
          default: st_q <= S_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive screening
  // ----------------------------------------------------------------
  logic [15:0] idx_q;
  logic [31:0] rx_crc_q;
  logic [7:0]  rfc_q, rc0_q, hi_q;
  logic [47:0] rda_q, rsa_q;
  logic [11:0] lan_q [RD_MAX];
  logic [11:0] plan_q;
  logic [3:0]  pbn_q, nrd_q;
  logic        dup_q, hop_q;

  // Field decode for the received octet
  wire        first_rx = idx_q == 16'h0000;
  wire [31:0] rx_crc_nx = crc_byte(first_rx ? `SRFP_CRC_INIT : rx_crc_q, rx_byte);
  wire        routing_info_indicator      = rsa_q[`SRFP_IG_BIT];
  wire        in_ri    = routing_info_indicator && idx_q >= `SRFP_IDX_RD && idx_q < `SRFP_IDX_RC0 + {11'h000, rc0_q[4:0]};
  wire        rd_done  = rx_valid && in_ri && !idx_q[0];
  wire [11:0] rd_lan   = {hi_q, rx_byte[7:4]};
  wire        seen     = lan_seen(rd_lan, nrd_q, lan_q);
  wire        pair_ok  = (plan_q == lan_in_id && rd_lan == lan_out_id) ||
                         (plan_q == lan_out_id && rd_lan == lan_in_id);
  wire        on_hop   = nrd_q != 4'h0 && pbn_q == bridge_num && pair_ok;
  wire        rx_end   = rx_valid && rx_last;
  wire        rx_good  = !rx_err && rx_crc_nx == `SRFP_CRC_GOOD && idx_q >= `SRFP_IDX_MIN;
  wire        own      = own_q != 4'h0;
  wire        llc      = rfc_q[7:6] == `SRFP_FC_LLC;
  wire        rx_expl  = rc0_q[7];
  wire        ind_d    = rx_good && !own && (mode_fddi || !routing_info_indicator || llc);
  wire        fwd_d    = !routing_info_indicator || (!dup_q && (rx_expl || hop_q));

  // Octet capture and route descriptor checks
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      idx_q    <= 16'h0000;
      rx_crc_q <= `SRFP_CRC_INIT;
      rfc_q    <= 8'h00;
      rc0_q    <= 8'h00;
      hi_q     <= 8'h00;
      rda_q    <= 48'h0;
      rsa_q    <= 48'h0;
      plan_q   <= 12'h000;
      pbn_q    <= 4'h0;
      nrd_q    <= 4'h0;
      dup_q    <= 1'b0;
      hop_q    <= 1'b0;
    end
    else if (rx_valid)
    begin
      idx_q    <= rx_last ? 16'h0000 : idx_q + {15'h0000, idx_q != `SRFP_IDX_MAX};
      rx_crc_q <= rx_crc_nx;
      if (first_rx)
      begin
        rfc_q <= rx_byte;
        nrd_q <= 4'h0;
        dup_q <= 1'b0;
        hop_q <= 1'b0;
      end
      if (idx_q >= `SRFP_IDX_DA && idx_q < `SRFP_IDX_SA)
        rda_q <= {rda_q[39:0], rx_byte};
      if (idx_q >= `SRFP_IDX_SA && idx_q < `SRFP_IDX_RC0)
        rsa_q <= {rsa_q[39:0], rx_byte};
      if (idx_q == `SRFP_IDX_RC0)
        rc0_q <= rx_byte;
      if (in_ri && idx_q[0])
        hi_q <= rx_byte;
      if (rd_done)
      begin
        dup_q  <= dup_q | seen;
        hop_q  <= hop_q | on_hop;
        plan_q <= rd_lan;
        pbn_q  <= rx_byte[3:0];
        if (int'(nrd_q) < RD_MAX)
        begin
          lan_q[nrd_q] <= rd_lan;
          nrd_q        <= nrd_q + 4'h1;
        end
      end
    end
  end

  // Indication toward the relay, and count of own frames still on the ring
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      own_q   <= 4'h0;
      rx_ind_valid <= 1'b0;
      rx_ind_sr    <= 1'b0;
      rx_ind_nsr   <= 1'b0;
      rx_fwd_ok    <= 1'b0;
      rx_rt        <= 3'h0;
      rx_fc        <= 8'h00;
      rx_da        <= 48'h0;
      rx_sa        <= 48'h0;
    end
    else
    begin
      // Our frames come back whatever source they carry, so count them
      own_q <= own_q + {3'h0, fs_out} - {3'h0, rx_end && own};
      rx_ind_valid <= rx_end && ind_d;
      if (rx_end)
      begin
        rx_ind_sr  <= routing_info_indicator;
        rx_ind_nsr <= !routing_info_indicator;
        rx_fwd_ok  <= fwd_d;
        rx_rt      <= routing_info_indicator ? rc0_q[7:5] : 3'h0;
        rx_fc      <= rfc_q;
        rx_da      <= rda_q;
        rx_sa      <= rsa_q;
      end
    end
  end

  assign tx_ready  = ready_q;
  assign tx_drop   = drop_q;
  assign phy_valid = phy_valid_q;
  assign phy_byte  = phy_byte_q;
  assign phy_last  = phy_last_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  a_buf_full_stall: assert property (cnt_q == 2'h2 |-> !ready_q)
    else $error("buffer full but ready high");
  a_oversize_drop: assert property (st_q == S_IDLE && pend_q && oversize && !port_flush
                                    |=> st_q == S_DROP)
    else $error("oversize frame not dropped");
  a_sa_indicator: assert property (st_q == S_SA && bc_q == 3'h0 && slot
                                   |=> phy_byte_q[0])
    else $error("indicator bit not set on source address");
  a_start_delim: assert property (st_q == S_SD && slot && !port_flush
                                  |=> phy_valid_q && phy_byte_q == `SRFP_SD
                                      && st_q == S_AC)
    else $error("start delimiter missing");
  a_expl_recalc: assert property (st_q == S_FCS && bc_q == 3'h0 && expl_q
                                  |-> fcs_sh_q == ~crc_tx_q)
    else $error("explorer check sequence not recomputed");
  a_fcs_passed: assert property (st_q == S_FCS && bc_q == 3'h0 && given_q && !expl_q
                                 |-> fcs_sh_q == fcs_in_q)
    else $error("supplied check sequence altered");
  a_strip_own: assert property (rx_end && own |=> !rx_ind_valid)
    else $error("own frame indicated");
  a_bad_frame: assert property (rx_end && !rx_good |=> !rx_ind_valid)
    else $error("bad frame indicated");
  a_dup_lan: assert property (rx_end && routing_info_indicator && dup_q |=> !rx_fwd_ok)
    else $error("repeated LAN forwarded");
  a_off_route: assert property (rx_end && routing_info_indicator && !rx_expl && !hop_q |=> !rx_fwd_ok)
    else $error("routed frame forwarded off route");
  a_nsr_path: assert property (rx_end && rx_good && !own && !routing_info_indicator
                               |=> rx_ind_valid && rx_ind_nsr)
    else $error("plain frame not sent to transparent path");
  a_fddi_ind: assert property (rx_end && rx_good && !own && mode_fddi |=> rx_ind_valid)
    else $error("dual-ring frame not indicated");
  a_flush_empty: assert property (port_flush |=> cnt_q == 2'h0 && st_q == S_IDLE && !ready_q)
    else $error("flush left state behind");

endmodule : srfp_port

// >>> rtl/srfp_defs.svh
// Constants for the source-routed ring frame port
`ifndef SRFP_DEFS_SVH
`define SRFP_DEFS_SVH

// Delimiter, access control and trailer octets added on the wire
`define SRFP_SD         8'hE6
`define SRFP_AC         8'h10
`define SRFP_ED         8'hF6
`define SRFP_FS         8'h00

// Address bits: group bit of DA, indicator bit of SA share one place
`define SRFP_IG_BIT     40
`define SRFP_RII_MASK   48'h0100_0000_0000

// Frame control class of user data frames
`define SRFP_FC_LLC     2'h1

// Reflected CRC-32 generator, start value and good residue
`define SRFP_CRC_POLY   32'hEDB8_8320
`define SRFP_CRC_INIT   32'hFFFF_FFFF
`define SRFP_CRC_GOOD   32'hDEBB_20E3

// Received octet positions, counted from frame control
`define SRFP_IDX_DA     16'h0001
`define SRFP_IDX_SA     16'h0007
`define SRFP_IDX_RC0    16'h000D
`define SRFP_IDX_RD     16'h000F
`define SRFP_IDX_MIN    16'h0010
`define SRFP_IDX_MAX    16'hFFFF

// Last octet indices in the transmit sequence, and the receive route descriptor limit
`define SRFP_ADDR_LAST  3'h5
`define SRFP_FCS_LAST   3'h3
`define SRFP_RD_MAX     14

`endif

// >>> rtl/srfp_pkg.sv
// Types shared by the source-routed ring frame port
package srfp_pkg;

  // Transmit sequencer, Gray coded along the normal path from S_IDLE up to S_FS
  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_SD   = 4'h1,
    S_AC   = 4'h3,
    S_FC   = 4'h2,
    S_DA   = 4'h6,
    S_SA   = 4'h7,
    S_BODY = 4'h5,
    S_FCS  = 4'h4,
    S_ED   = 4'hC,
    S_FS   = 4'hD,
    S_DROP = 4'h8
  } srfp_state_e;

  typedef logic [7:0] srfp_byte_t;

endpackage : srfp_pkg

// >>> bench/srfp_relay_model.sv
// Relay-side partner model: offers transmit frames beat by beat
module srfp_relay_model
  import srfp_pkg::*;
(
  input  wire logic  sys_clk,
  input  wire logic  tx_ready,
  output logic       tx_valid,
  output srfp_byte_t tx_byte,
  output logic       tx_last,
  output logic [7:0] tx_fc,
  output logic [47:0] tx_da,
  output logic [47:0] tx_sa,
  output logic [15:0] tx_msdu_len,
  output logic [31:0] tx_fcs,
  output logic       tx_fcs_given
);
  timeunit 1ns;
  timeprecision 1ps;

  logic slow  = 1'b0;  // Idle cycle after each beat when set
  int   hangs = 0;

  // Quiet request lines from time zero
  initial
  begin
    {tx_valid, tx_last, tx_fcs_given} = 3'h0;
    {tx_byte, tx_fc, tx_msdu_len, tx_fcs, tx_da, tx_sa} = '0;
  end

  // Body carries routing field already edited by the relay; beat held until taken
  task automatic send(input logic [7:0] fc, input logic [47:0] da, input logic [47:0] sa,
                      input logic [15:0] len, input logic [31:0] fcs, input logic given,
                      input srfp_byte_t body[$]);
    int w;
    {tx_fc, tx_da, tx_sa, tx_msdu_len, tx_fcs, tx_fcs_given} <= {fc, da, sa, len, fcs, given};
    foreach (body[i])
    begin
      tx_valid <= 1'b1;
      tx_byte  <= body[i];
      tx_last  <= (i == body.size() - 1);
      w = 0;
      do
      begin
        @(posedge sys_clk);
        w++;
      end
      while (tx_ready !== 1'b1 && w < 300);
      if (w >= 300)
        hangs++;
      if (slow)
      begin
        tx_valid <= 1'b0;
        tx_byte  <= ~body[i];
        @(posedge sys_clk);
      end
    end
    tx_valid <= 1'b0;
    tx_byte  <= ~tx_byte;  // Released line shows no stale octet
    @(posedge sys_clk);
  endtask : send
endmodule : srfp_relay_model

// >>> bench/testbench.sv
// Self-checking bench for the source-routed ring frame port
`include "srfp_defs.svh"
module testbench
  import srfp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef srfp_byte_t srfp_bq_t[$];
  typedef logic [8:0] srfp_wire_t;

  // ----------------------------------------
  // Signals and constants
  // ----------------------------------------
  logic sys_clk = 1'b0, rst = 1'b1, port_flush = 1'b0, mode_fddi = 1'b0, stall = 1'b0;
  logic hold = 1'b0, phy_ready = 1'b1, rx_valid = 1'b0, rx_last = 1'b0, rx_err = 1'b0;
  logic [15:0] lan_in_max = 16'h0040, lan_out_max = 16'h0100;
  srfp_byte_t rx_byte = 8'h00;
  logic tx_valid, tx_last, tx_fcs_given, tx_ready, tx_drop, phy_valid, phy_last;
  logic rx_ind_valid, rx_ind_sr, rx_ind_nsr, rx_fwd_ok;
  logic [7:0] tx_byte, tx_fc, phy_byte, rx_fc;
  logic [2:0] rx_rt;
  logic [47:0] tx_da, tx_sa, rx_da, rx_sa;
  logic [15:0] tx_msdu_len;
  logic [31:0] tx_fcs;
  localparam logic [47:0] da_c = 48'h4000_0000_0012;
  localparam logic [47:0] sa_rii = 48'h0100_0000_0034;
  localparam logic [47:0] sa_plain = 48'h0200_0000_0034;
  localparam logic [7:0] fc_user = 8'h40;
  // Our hop is LAN 0A1, bridge 3, LAN 0B2
  srfp_bq_t hop = '{8'h06, 8'h00, 8'h0A, 8'h13, 8'h0B, 8'h20, 8'h55};
  srfp_bq_t dup = '{8'h08, 8'h00, 8'h0A, 8'h13, 8'h0B, 8'h25, 8'h0A, 8'h10};
  srfp_bq_t far = '{8'h06, 8'h00, 8'h0A, 8'h17, 8'h0B, 8'h20, 8'h55};
  srfp_bq_t two = '{8'h55, 8'h55};
  srfp_bq_t rcz = '{8'h00, 8'h00};
  srfp_byte_t rts[6] = '{8'h06, 8'h26, 8'h66, 8'h86, 8'hA6, 8'hE6};
  srfp_wire_t wire_q[$], exp_q[$];
  int cyc = 0, n_ind = 0, n_drop = 0, n_mismatch = 0, cmp_count = 0;

  always #5 sys_clk = ~sys_clk;

  srfp_relay_model relay_u (.sys_clk(sys_clk), .tx_ready(tx_ready), .tx_valid(tx_valid),
    .tx_byte(tx_byte), .tx_last(tx_last), .tx_fc(tx_fc), .tx_da(tx_da), .tx_sa(tx_sa),
    .tx_msdu_len(tx_msdu_len), .tx_fcs(tx_fcs), .tx_fcs_given(tx_fcs_given));

  srfp_port dut_u (.sys_clk(sys_clk), .rst(rst), .port_flush(port_flush),
    .mode_fddi(mode_fddi), .lan_in_id(12'h0A1), .lan_out_id(12'h0B2), .bridge_num(4'h3),
    .lan_in_max(lan_in_max), .lan_out_max(lan_out_max), .tx_valid(tx_valid),
    .tx_byte(tx_byte), .tx_last(tx_last), .tx_fc(tx_fc), .tx_da(tx_da), .tx_sa(tx_sa),
    .tx_msdu_len(tx_msdu_len), .tx_fcs(tx_fcs), .tx_fcs_given(tx_fcs_given),
    .tx_ready(tx_ready), .tx_drop(tx_drop), .phy_ready(phy_ready), .phy_valid(phy_valid),
    .phy_byte(phy_byte), .phy_last(phy_last), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .rx_last(rx_last), .rx_err(rx_err), .rx_ind_valid(rx_ind_valid), .rx_ind_sr(rx_ind_sr),
    .rx_ind_nsr(rx_ind_nsr), .rx_fwd_ok(rx_fwd_ok), .rx_rt(rx_rt), .rx_fc(rx_fc),
    .rx_da(rx_da), .rx_sa(rx_sa));

  // Medium stalls one cycle in four when asked; counts pulses and taken octets
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    phy_ready <= !hold && !(stall && cyc[1:0] == 2'h3);
    if (phy_valid === 1'b1 && phy_ready === 1'b1)
      wire_q.push_back({phy_last, phy_byte});
    if (tx_drop === 1'b1)
      n_drop <= n_drop + 1;
    if (rx_ind_valid === 1'b1)
      n_ind <= n_ind + 1;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic [31:0] crc_of(srfp_bq_t b);
    logic [31:0] c;
    c = `SRFP_CRC_INIT;
    foreach (b[i])
    begin
      c = c ^ {24'h000000, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ `SRFP_CRC_POLY : c >> 1;
    end
    return ~c;
  endfunction : crc_of

  // Octets covered by the check sequence, address octets most significant first
  function automatic srfp_bq_t image(logic [7:0] fc, logic [47:0] sa, srfp_bq_t body);
    srfp_bq_t q;
    q.push_back(fc);
    for (int i = 5; i >= 0; i--) q.push_back(da_c[i*8 +: 8]);
    for (int i = 5; i >= 0; i--) q.push_back(sa[i*8 +: 8]);
    return {q, body};
  endfunction : image

  function automatic srfp_bq_t rxf(logic [7:0] fc, logic [47:0] sa, srfp_bq_t body);
    srfp_bq_t q;
    logic [31:0] c;
    q = image(fc, sa, body);
    c = crc_of(q);
    for (int i = 0; i < 4; i++) q.push_back(c[i*8 +: 8]);
    return q;
  endfunction : rxf

  task automatic rx_send(input srfp_bq_t f, input logic err, input int exp_ind);
    int k;
    k = n_ind;
    foreach (f[i])
    begin
      {rx_valid, rx_byte, rx_last, rx_err} <= {1'b1, f[i], i == f.size() - 1, err};
      @(posedge sys_clk);
    end
    {rx_valid, rx_last, rx_byte} <= {2'h0, ~rx_byte};
    repeat (3) @(posedge sys_clk);
    check("indications", 64'(n_ind - k), 64'(exp_ind));
  endtask : rx_send

  // Queue the expected wire image, then let the relay offer the frame
  task automatic tx(input logic [15:0] len, input logic [31:0] fcs, input logic given,
                    input srfp_bq_t body);
    srfp_bq_t q;
    logic [31:0] c;
    q = image(fc_user, sa_plain, body);
    q[7] = q[7] | 8'h01;  // Indicator expected in first source octet
    c = (given && !body[0][7]) ? fcs : crc_of(q);
    exp_q.push_back({1'b0, `SRFP_SD});
    exp_q.push_back({1'b0, `SRFP_AC});
    foreach (q[i]) exp_q.push_back({1'b0, q[i]});
    for (int i = 0; i < 4; i++) exp_q.push_back({1'b0, c[i*8 +: 8]});
    exp_q.push_back({1'b0, `SRFP_ED});
    exp_q.push_back({1'b1, `SRFP_FS});
    relay_u.send(fc_user, da_c, sa_plain, len, fcs, given, body);
  endtask : tx

  task automatic wire_check;
    int w;
    w = 0;
    while (wire_q.size() < exp_q.size() && w < 3000)
    begin
      @(posedge sys_clk);
      w++;
    end
    repeat (6) @(posedge sys_clk);
    check("octet count", 64'(wire_q.size()), 64'(exp_q.size()));
    foreach (exp_q[i])
      if (i < wire_q.size())
        check("octet", 64'(wire_q[i]), 64'(exp_q[i]));
    wire_q = {};
    exp_q = {};
  endtask : wire_check

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic sc_rx;
    srfp_bq_t f;
    rx_send(rxf(fc_user, sa_rii, hop), 1'b0, 1);
    check("sr", 64'(rx_ind_sr), 64'h1);
    check("fwd", 64'(rx_fwd_ok), 64'h1);
    check("fc", 64'(rx_fc), 64'(fc_user));
    check("da", 64'(rx_da), 64'(da_c));
    check("sa", 64'(rx_sa), 64'(sa_rii));
    rx_send(rxf(fc_user, sa_rii, hop), 1'b1, 0);
    f = rxf(fc_user, sa_rii, hop);
    f[9] = f[9] ^ 8'h04;
    rx_send(f, 1'b0, 0);
    rx_send(rxf(fc_user, sa_rii, dup), 1'b0, 1);
    check("fwd dup", 64'(rx_fwd_ok), 64'h0);
    rx_send(rxf(fc_user, sa_rii, far), 1'b0, 1);
    check("fwd far", 64'(rx_fwd_ok), 64'h0);
    rx_send(rxf(fc_user, sa_plain, two), 1'b0, 1);
    check("nsr", 64'({rx_ind_nsr, rx_ind_sr, rx_rt}), 64'h10);
    rx_send(rxf(8'h00, sa_rii, hop), 1'b0, 0);
    mode_fddi <= 1'b1;
    rx_send(rxf(8'h00, sa_rii, hop), 1'b0, 1);
    mode_fddi <= 1'b0;
    foreach (rts[i])
    begin
      f = hop;
      f[0] = rts[i];
      rx_send(rxf(fc_user, sa_rii, f), 1'b0, 1);
      check("routing type", 64'(rx_rt), 64'(rts[i][7:5]));
    end
  endtask : sc_rx

  task automatic sc_order_strip;
    srfp_bq_t b;
    b = hop;
    b[6] = 8'hA5;
    stall <= 1'b1;
    tx(16'h0010, 32'h1234_5678, 1'b1, hop);
    tx(16'h0010, 32'h0000_0000, 1'b0, b);
    wire_check;
    rx_send(rxf(fc_user, sa_rii, hop), 1'b0, 0);
    rx_send(rxf(fc_user, sa_plain, two), 1'b0, 0);
    rx_send(rxf(fc_user, sa_rii, hop), 1'b0, 1);
  endtask : sc_order_strip

  task automatic sc_explorer;
    srfp_bq_t b;
    b = hop;
    relay_u.slow = 1'b1;
    b[0] = 8'h86;
    tx(16'h0010, 32'hDEAD_0001, 1'b1, b);
    b[0] = 8'hC6;
    tx(16'h0010, 32'hDEAD_0002, 1'b1, b);
    wire_check;
    relay_u.slow = 1'b0;
    stall <= 1'b0;
  endtask : sc_explorer

  task automatic sc_size;
    relay_u.send(fc_user, da_c, sa_plain, 16'h0041, 32'h0, 1'b0, hop);
    repeat (10) @(posedge sys_clk);
    check("drops", 64'(n_drop), 64'h1);
    check("oversize octets", 64'(wire_q.size()), 64'h0);
    tx(16'h0040, 32'h0, 1'b0, hop);
    wire_check;
    lan_out_max <= 16'h0030;
    relay_u.send(fc_user, da_c, sa_plain, 16'h0040, 32'h0, 1'b0, hop);
    repeat (10) @(posedge sys_clk);
    check("drops", 64'(n_drop), 64'h2);
    check("oversize octets", 64'(wire_q.size()), 64'h0);
    lan_out_max <= 16'h0100;
  endtask : sc_size

  task automatic sc_flush;
    hold <= 1'b1;
    relay_u.send(fc_user, da_c, sa_plain, 16'h0010, 32'h0, 1'b0, rcz);
    repeat (4) @(posedge sys_clk);
    port_flush <= 1'b1;
    @(posedge sys_clk);
    port_flush <= 1'b0;
    hold <= 1'b0;
    repeat (40) @(posedge sys_clk);
    // Delimiter already offered stays up until taken; nothing follows it
    check("flushed octets", 64'(wire_q.size()), 64'h1);
    check("cut octet", 64'(wire_q[0]), 64'({1'b0, `SRFP_SD}));
    wire_q = {};
    check("ready", 64'(tx_ready), 64'h1);
    tx(16'h0010, 32'h0, 1'b0, hop);
    wire_check;
  endtask : sc_flush

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  // Main sequence, with a watchdog that cuts a hang short
  initial
  begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    sc_rx;
    sc_order_strip;
    sc_explorer;
    sc_size;
    sc_flush;
    check("relay waits", 64'(relay_u.hangs), 64'h0);
    test_done;
  end

  initial
  begin
    repeat (90000) @(posedge sys_clk);
    check("run length", 64'h1, 64'h0);
    test_done;
  end
endmodule : testbench
